/* File: test/sdms_ctrl.sv */
// Motion controller model that drives the step and direction pins
`timescale 1ns/1ps
module sdms_ctrl (
  // Clock
  input wire logic mclk,
  // Step and direction pins
  output logic step_pin,
  output logic dir_pin
);
  initial begin
    step_pin = 1'b0;
    dir_pin = 1'b0;
  end

  // One step; rise to next rise is per cycles, per at least 6
  task automatic pulse(input logic d, input int per);
    @(negedge mclk);
    dir_pin = d;
    repeat (3) @(negedge mclk);
    step_pin = 1'b1;
    repeat (2) @(negedge mclk);
    step_pin = 1'b0;
    repeat (per - 6) @(negedge mclk);
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench of the step/direction microstep sequencer
`timescale 1ns/1ps
module tb_top;
  logic mclk;
  logic nrst;
  logic step_pin;
  logic dir_pin;
  logic power_down_select_pin;
  logic [sdms_pkg::RES_W-1:0] res_sel;
  sdms_pkg::sdms_coil_type coil;
  logic [sdms_pkg::POS_W-1:0] pos_out;
  logic index_out;
  logic stst_out;
  logic standby_out;
  int n_errors;
  int checks;

  sdms_ctrl ctrl (.mclk(mclk), .step_pin(step_pin), .dir_pin(dir_pin));

  sdms_seq #(.STST_CYCLES(21'h000040)) uut (
    .mclk(mclk), .nrst(nrst), .step_pin(step_pin), .dir_pin(dir_pin),
    .power_down_select_pin(power_down_select_pin), .res_sel(res_sel), .coil(coil),
    .pos_out(pos_out), .index_out(index_out), .stst_out(stst_out),
    .standby_out(standby_out)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_pos(input logic [9:0] exp);
    int i;
    for (i = 0; i < 600; i++) begin
      @(negedge mclk);
      if (pos_out === exp) break;
    end
    if (i == 600) begin
      n_errors++;
      $display("FAIL %0t position wait ran out", $time);
      complete_run();
    end
  endtask

  task automatic step_to(input logic d, input int per, input logic [9:0] exp);
    ctrl.pulse(d, per);
    wait_pos(exp);
    check(pos_out, exp, "position");
  endtask

  // Cycles between the third and fourth position change
  task automatic meas(input int exp);
    logic [9:0] p;
    int n;
    int k;
    int t0;
    p = pos_out;
    k = 0;
    t0 = 0;
    for (n = 0; n < 200 && k < 4; n++) begin
      @(negedge mclk);
      if (pos_out !== p) begin
        k++;
        p = pos_out;
        if (k == 3) t0 = n;
        if (k == 4) check(n - t0, exp, "microstep spacing");
      end
    end
    if (k < 4) check(k, 4, "microstep count");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    check(pos_out, 10'h000, "reset position");
    check(index_out, 1'b1, "index at zero");
    check(coil.a, 9'sh000, "coil a at zero");
    check(coil.b, 9'sh0ff, "coil b at zero");
    step_to(1'b0, 16, 10'h001);
    check(index_out, 1'b0, "index off zero");
    step_to(1'b1, 16, 10'h000);
    check(index_out, 1'b1, "index back at zero");
  endtask

  task automatic s_snap();
    logic [9:0] p;
    step_to(1'b0, 16, 10'h001);
    res_sel = 4'h6;
    wait_pos(10'h020);
    check(pos_out, 10'h020, "quarter snap");
    step_to(1'b0, 16, 10'h060);
    res_sel = 4'h7;
    wait_pos(10'h040);
    check(pos_out, 10'h040, "half snap");
    step_to(1'b0, 16, 10'h0c0);
    res_sel = 4'h8;
    wait_pos(10'h080);
    check(pos_out, 10'h080, "full snap");
    check(coil.a, coil.b, "equal coils");
    // Settings above full step act as full step
    res_sel = 4'hf;
    p = 10'h080;
    for (int k = 0; k < 4; k++) begin
      p = p + 10'h100;
      step_to(1'b0, 16, p);
      check(pos_out[7:0], 8'h80, "full step grid");
      if (k == 0) check(coil.a, -coil.b, "opposite coils");
    end
    step_to(1'b1, 16, 10'h380);
  endtask

  task automatic s_standstill();
    check(stst_out, 1'b1, "standstill set");
    check(standby_out, 1'b1, "standby on");
    power_down_select_pin = 1'b0;
    repeat (8) @(negedge mclk);
    check(standby_out, 1'b0, "standby off");
    res_sel = 4'h4;
  endtask

  task automatic s_interp();
    ctrl.pulse(1'b0, 48);
    check(stst_out, 1'b0, "standstill cleared");
    ctrl.pulse(1'b0, 48);
    fork
      ctrl.pulse(1'b0, 32);
      meas(3);
    join
    fork
      ctrl.pulse(1'b0, 32);
      meas(2);
    join
    wait_pos(10'h3c0);
    check(pos_out, 10'h3c0, "final position");
  endtask

  initial begin
    nrst = 1'b0;
    power_down_select_pin = 1'b1;
    res_sel = 4'h0;
    n_errors = 0;
    checks = 0;
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    s_reset();
    s_snap();
    s_standstill();
    s_interp();
    complete_run();
  end
endmodule

/* File: verilog/sdms_pkg.sv */
// Shared constants and carrier types of the step/direction microstep sequencer
package sdms_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STST_LOG2 = 20;
  localparam int CNT_W = STST_LOG2 + 1;
  localparam logic [CNT_W-1:0] STST_CYCLES = 21'h100000;
  localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;

  // ---------------------------------------------------------------
  // Microstep table and resolution
  // ---------------------------------------------------------------
  localparam int POS_W = 10;
  localparam int RES_W = 4;
  localparam logic [RES_W-1:0] RES_FINEST = 4'h0;
  localparam logic [RES_W-1:0] RES_QUARTER = 4'h6;
  localparam logic [RES_W-1:0] RES_HALF = 4'h7;
  localparam logic [RES_W-1:0] RES_FULL = 4'h8;
  localparam logic [POS_W-1:0] POS_ONE = 10'h001;
  localparam logic [POS_W-1:0] POS_ZERO = 10'h000;
  localparam logic [7:0] FULL_ORIGIN = 8'h80;
  localparam logic [6:0] HALF_ORIGIN = 7'h40;
  localparam logic [5:0] QUARTER_ORIGIN = 6'h20;
  localparam logic [POS_W-1:0] COS_SHIFT = 10'h100;

  // ---------------------------------------------------------------
  // Coil amplitude
  // ---------------------------------------------------------------
  localparam int AMP_W = 9;
  localparam int SEG_W = 4;
  localparam logic [4:0] SEG_LAST = 5'h10;

  // ---------------------------------------------------------------
  // Pin synchroniser length
  // ---------------------------------------------------------------
  localparam int SYNC_LEN = 3;

  typedef struct packed {
    logic signed [AMP_W-1:0] a;
    logic signed [AMP_W-1:0] b;
  } sdms_coil_type;

  typedef struct packed {
    logic [SYNC_LEN-1:0] step_sync;
    logic [SYNC_LEN-1:0] dir_sync;
    logic [SYNC_LEN-1:0] pdn_sync;
    logic step_f;
    logic dir_f;
    logic pdn_f;
    logic [RES_W-1:0] res;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] target;
    logic move_dn;
    logic [CNT_W-1:0] ivl_cnt;
    logic [CNT_W-1:0] ivl;
    logic [CNT_W-1:0] tick;
    logic stst;
    logic standby;
    logic index;
    sdms_coil_type coil;
  } sdms_state_type;

endpackage

/* File: verilog/sdms_seq.sv */
// Step/direction input, microstep sequencer, interpolator and standstill detection
//
// What this block does
// - Only rising step edges move the sequence; falling edges do nothing.
// - Step and direction pass a synchroniser before edge detection and use.
// - A 10-bit counter addresses a 1024-position sine table, one electrical period.
// - Each step adds the step width with direction low, subtracts it with high.
// - Step width is 1 at finest, doubling per coarser setting up to 256.
// - Switching coarser moves the counter to the nearest valid position at once.
// - Full stepping targets 128, 384, 640, 896 only, 256 apart.
// - Entered from a finer setting, half steps start at 64 spaced 128; quarter steps at 32 spaced 64.
// - Each step is played out as a run of single microsteps.
// - Previous step interval is divided evenly over the microsteps of one step.
// - No step edge for 2^20 clocks raises a standstill event.
// - Standstill starts standby current reduction only when power-down select is set.
// - Standstill flag is set on detection and cleared by the next step edge.
// - New microstep spacing applies once a full interval at the new rate is measured.
// - A step edge before the run ends skips the remaining microsteps.
// - Index output is active at the positive zero crossing of coil A.
`timescale 1ns/1ps
module sdms_seq #(
  parameter logic [sdms_pkg::CNT_W-1:0] STST_CYCLES = sdms_pkg::STST_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Motion controller pins
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic power_down_select_pin,
  // Resolution select, 0 finest to 8 full step
  input wire logic [sdms_pkg::RES_W-1:0] res_sel,
  // Coil current vector
  output sdms_pkg::sdms_coil_type coil,
  // Status
  output logic [sdms_pkg::POS_W-1:0] pos_out,
  output logic index_out,
  output logic stst_out,
  output logic standby_out
);

  sdms_pkg::sdms_state_type q;
  sdms_pkg::sdms_state_type d;
  sdms_pkg::sdms_coil_type wave;
  logic rise;
  logic coarser;
  logic [sdms_pkg::RES_W-1:0] res_n;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Table stride of a resolution setting
  function automatic logic [sdms_pkg::POS_W-1:0] width(
    input logic [sdms_pkg::RES_W-1:0] r);
    width = sdms_pkg::POS_ONE << r;
  endfunction

  // Nearest valid position: centre of the stride-wide bin holding t
  function automatic logic [sdms_pkg::POS_W-1:0] align(
    input logic [sdms_pkg::POS_W-1:0] t,
    input logic [sdms_pkg::RES_W-1:0] r);
    logic [sdms_pkg::POS_W-1:0] w;
    w = width(r);
    align = (t & ~(w - sdms_pkg::POS_ONE)) + (w >> 1);
  endfunction

  // ---------------------------------------------------------------
  // Edge and resolution decode
  // ---------------------------------------------------------------
  always_comb begin
    rise = (q.step_sync[1] == q.step_sync[2]) && q.step_sync[1] && !q.step_f;
    res_n = (res_sel > sdms_pkg::RES_FULL) ? sdms_pkg::RES_FULL : res_sel;
    coarser = res_n > q.res;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [sdms_pkg::POS_W-1:0] base;
    logic [sdms_pkg::CNT_W-1:0] spacing;
    base = q.target;
    spacing = q.ivl >> q.res;
    d = q;

    // Three-stage sampling; a level counts once stages two and three agree
    d.step_sync = {q.step_sync[1:0], step_pin};
    d.dir_sync = {q.dir_sync[1:0], dir_pin};
    d.pdn_sync = {q.pdn_sync[1:0], power_down_select_pin};
    if (q.step_sync[1] == q.step_sync[2]) begin
      d.step_f = q.step_sync[1];
    end
    if (q.dir_sync[1] == q.dir_sync[2]) begin
      d.dir_f = q.dir_sync[1];
    end
    if (q.pdn_sync[1] == q.pdn_sync[2]) begin
      d.pdn_f = q.pdn_sync[1];
    end

    // Resolution change; coarser snaps position and target together
    d.res = res_n;
    if (coarser) begin
      base = align(q.target, res_n);
      d.target = base;
      d.pos = base;
      d.tick = '0;
    end

    if (spacing == '0) begin
      spacing = sdms_pkg::CNT_ONE;
    end

    if (rise) begin
      // Measured interval is kept for the next run only
      d.ivl = q.ivl_cnt;
      d.ivl_cnt = sdms_pkg::CNT_ONE;
      d.stst = 1'b0;
      d.pos = base;
      d.move_dn = d.dir_f;
      d.target = d.dir_f ? base - width(res_n) : base + width(res_n);
      d.tick = '0;
    end else begin
      if (q.ivl_cnt >= STST_CYCLES) begin
        d.stst = 1'b1;
      end else begin
        d.ivl_cnt = q.ivl_cnt + sdms_pkg::CNT_ONE;
      end
      if (!coarser) begin
        if (q.pos != q.target) begin
          if (q.tick >= spacing - sdms_pkg::CNT_ONE) begin
            d.tick = '0;
            d.pos = q.move_dn ? q.pos - sdms_pkg::POS_ONE
                              : q.pos + sdms_pkg::POS_ONE;
          end else begin
            d.tick = q.tick + sdms_pkg::CNT_ONE;
          end
        end else begin
          d.tick = '0;
        end
      end
    end

    d.standby = d.stst && d.pdn_f;
    d.index = (d.pos == sdms_pkg::POS_ZERO);
    d.coil = wave;
  end

  // Amplitudes of the next position, registered with it
  sdms_wave u_wave (
    .pos(d.pos),
    .coil(wave)
  );

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    coil = q.coil;
    pos_out = q.pos;
    index_out = q.index;
    stst_out = q.stst;
    standby_out = q.standby;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_accept;
    rise && !coarser;
  endsequence

  sequence s_idle;
    !rise && !coarser;
  endsequence

  sequence s_fall;
    q.step_f && !q.step_sync[1] && !q.step_sync[2];
  endsequence

  sequence s_rest;
    s_idle ##0 (q.pos == q.target);
  endsequence

  a_fall_no_move: assert property (
    s_idle |=> $stable(q.target))
    else $error("target moved without a rising step edge");

  a_sync_stages: assert property (
    rise |-> q.step_sync[2] && $past(q.step_sync[1]) && !$past(q.step_f))
    else $error("step edge accepted before synchroniser agreed");

  a_step_width: assert property (
    s_accept |=> q.target == (q.dir_f ?
      $past(q.target) - width(q.res) : $past(q.target) + width(q.res)))
    else $error("target did not move by the step width");

  a_full_grid: assert property (
    q.res == sdms_pkg::RES_FULL |-> q.target[7:0] == sdms_pkg::FULL_ORIGIN)
    else $error("full step target off grid");

  a_half_grid: assert property (
    q.res == sdms_pkg::RES_HALF |-> q.target[6:0] == sdms_pkg::HALF_ORIGIN)
    else $error("half step target off grid");

  a_quarter_grid: assert property (
    q.res == sdms_pkg::RES_QUARTER |-> q.target[5:0] == sdms_pkg::QUARTER_ORIGIN)
    else $error("quarter step target off grid");

  a_coarse_snap: assert property (
    coarser && !rise |=> q.pos == q.target && q.pos == align($past(q.target), q.res))
    else $error("coarser resolution did not snap to nearest position");

  a_stst_set: assert property (
    (q.ivl_cnt >= STST_CYCLES) && !rise |=> q.stst)
    else $error("standstill not flagged after timeout");

  a_stst_clear: assert property (
    rise |=> !q.stst ##1 (q.ivl_cnt == sdms_pkg::CNT_ONE + sdms_pkg::CNT_ONE || rise))
    else $error("standstill not cleared by step edge");

  a_standby_gate: assert property (
    q.standby |-> q.stst && q.pdn_f)
    else $error("standby without standstill and power-down select");

  a_skip_rest: assert property (
    s_accept |=> q.pos == $past(q.target))
    else $error("remaining microsteps not skipped on new step");

  a_single_micro: assert property (
    s_idle ##1 $changed(q.pos) |->
      (q.pos - $past(q.pos) == sdms_pkg::POS_ONE) ||
      ($past(q.pos) - q.pos == sdms_pkg::POS_ONE))
    else $error("position moved by more than one microstep");

  a_index_zero: assert property (
    index_out |-> pos_out == sdms_pkg::POS_ZERO && coil.a == '0)
    else $error("index active away from coil A zero");

  a_rate_ivl: assert property (
    rise |=> q.ivl == $past(q.ivl_cnt))
    else $error("interval not captured on step edge");

  a_fall_ignored: assert property (
    s_fall ##0 !coarser |=> $stable(q.target))
    else $error("target moved on a falling step edge");

  a_width_fine: assert property (
    s_accept ##0 (res_n == sdms_pkg::RES_FINEST) |=>
      (q.target - $past(q.target) == sdms_pkg::POS_ONE) ||
      ($past(q.target) - q.target == sdms_pkg::POS_ONE))
    else $error("finest step width is not one position");

  a_width_full: assert property (
    s_accept ##0 (res_n == sdms_pkg::RES_FULL) |=>
      (q.target - $past(q.target) == (sdms_pkg::POS_ONE << sdms_pkg::RES_FULL)) ||
      ($past(q.target) - q.target == (sdms_pkg::POS_ONE << sdms_pkg::RES_FULL)))
    else $error("full step width is not a quarter period");

  a_coil_zero: assert property (
    pos_out[8:0] == '0 |-> coil.a == '0)
    else $error("coil A not zero at a zero crossing");

  a_coil_pos: assert property (
    !pos_out[9] && pos_out[8:0] != '0 |-> coil.a > 9'sh000)
    else $error("coil A not positive in the first half period");

  a_coil_neg: assert property (
    pos_out[9] && pos_out[8:0] != '0 |-> coil.a < 9'sh000)
    else $error("coil A not negative in the second half period");

  a_stst_hold: assert property (
    q.stst && !rise |=> q.stst)
    else $error("standstill flag dropped without a step edge");

  a_standby_on: assert property (
    q.stst && q.pdn_f |-> q.standby)
    else $error("standby missing at standstill with power-down select");

  a_run_rest: assert property (
    s_rest |=> $stable(q.pos))
    else $error("position moved while resting on target");

  a_tick_bound: assert property (
    (q.ivl >> q.res) != '0 |-> q.tick < (q.ivl >> q.res))
    else $error("microstep tick ran past its spacing");

  a_ivl_sat: assert property (
    q.ivl_cnt <= STST_CYCLES)
    else $error("interval counter ran past the standstill limit");

  a_stst_cause: assert property (
    $rose(q.stst) |-> $past(q.ivl_cnt) >= STST_CYCLES)
    else $error("standstill raised before the timeout");

endmodule

/* File: verilog/sdms_wave.sv */
// Sine and cosine coil amplitudes from a microstep table position
`timescale 1ns/1ps
module sdms_wave (
  // Table position
  input wire logic [sdms_pkg::POS_W-1:0] pos,
  // Coil amplitudes
  output sdms_pkg::sdms_coil_type coil
);

  // ---------------------------------------------------------------
  // Quarter wave, 17 points, full scale 255
  // ---------------------------------------------------------------
  function automatic logic [11:0] tab(input logic [4:0] i);
    case (i)
      5'h00: tab = 12'h000;
      5'h01: tab = 12'h019;
      5'h02: tab = 12'h032;
      5'h03: tab = 12'h04a;
      5'h04: tab = 12'h062;
      5'h05: tab = 12'h079;
      5'h06: tab = 12'h08e;
      5'h07: tab = 12'h0a2;
      5'h08: tab = 12'h0b4;
      5'h09: tab = 12'h0c5;
      5'h0a: tab = 12'h0d4;
      5'h0b: tab = 12'h0e1;
      5'h0c: tab = 12'h0ec;
      5'h0d: tab = 12'h0f4;
      5'h0e: tab = 12'h0fa;
      5'h0f: tab = 12'h0fe;
      default: tab = 12'h0ff;
    endcase
  endfunction

  // Signed sine of a full table position, mirrored from one quarter
  function automatic logic signed [sdms_pkg::AMP_W-1:0] sine(
    input logic [sdms_pkg::POS_W-1:0] p);
    logic [8:0] x;
    logic [4:0] idx;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] mag;
    x = p[8] ? (9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
    idx = x[8:4];
    lo = tab(idx);
    hi = (idx == sdms_pkg::SEG_LAST) ? lo : tab(idx + 5'h01);
    mag = lo + (((hi - lo) * {8'h00, x[3:0]}) >> sdms_pkg::SEG_W);
    sine = p[9] ? -$signed({1'b0, mag[7:0]}) : $signed({1'b0, mag[7:0]});
  endfunction

  // Coil A is the sine, coil B the cosine
  always_comb begin
    coil.a = sine(pos);
    coil.b = sine(pos + sdms_pkg::COS_SHIFT);
  end

endmodule
